/* bench/plp_port_config_sva.sv */
// assertions on the ports of the per-port lookup and ptp register bank
`timescale 1ns/10ps
module plp_port_config_sva (
  input wire        pclk,
  input wire        presetn,
  input wire        ce,
  input wire        psel,
  input wire        penable,
  input wire        pready,
  input wire        pslverr,
  input wire [31:0] prdata,
  input wire        frm_valid,
  input wire        frm_tagged,
  input wire [11:0] frm_vid,
  input wire [11:0] lookup_vid,
  input wire        frm_drop,
  input wire        frm_learn,
  input wire        ptp_valid,
  input wire        ptp_corr_valid,
  input wire [63:0] ptp_corr_out,
  input wire [15:0] rx_wire_delay_ns,
  input wire [15:0] tx_wire_delay_ns,
  input wire        port_tx_en
);
  // ---------------------------------------------
  // checks
  // ---------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ans_wait_a: assert property (psel && penable && ce && !pready |=> pready)
    else $error("no answer one cycle after access");
  ans_pulse_a: assert property (pready && ce |=> !pready)
    else $error("ready held longer than one cycle");
  err_zero_a: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("refused access without ready or with data");
  ready_cause_a: assert property ($rose(pready) |-> $past(psel && penable))
    else $error("ready without an access");
  vid_pass_a: assert property (frm_valid && ce && frm_tagged && frm_vid != 12'h000
    |=> lookup_vid == $past(frm_vid)) else $error("tagged vid not used for lookup");
  frame_cause_a: assert property (frm_drop || frm_learn |-> $past(frm_valid))
    else $error("drop or learn without a frame");
  ptp_ans_a: assert property (ptp_valid && ce |=> ptp_corr_valid)
    else $error("no corrected value after request");
  ptp_hold_a: assert property (!ptp_corr_valid |-> $stable(ptp_corr_out))
    else $error("corrected value moved without valid");
  rst_val_a: assert property (disable iff (1'b0) !presetn |-> rx_wire_delay_ns ==
    16'h019f && tx_wire_delay_ns == 16'h002d && port_tx_en) else $error("bad reset value");
  cover property (pslverr);
  cover property (frm_drop);
  cover property (ptp_corr_valid);
endmodule // plp_port_config_sva

bind plp_port_config plp_port_config_sva u_sva (.pclk, .presetn, .ce, .psel, .penable,
  .pready, .pslverr, .prdata, .frm_valid, .frm_tagged, .frm_vid, .lookup_vid, .frm_drop,
  .frm_learn, .ptp_valid, .ptp_corr_valid, .ptp_corr_out, .rx_wire_delay_ns,
  .tx_wire_delay_ns, .port_tx_en);

/* bench/plp_port_config_tb.sv */
// self-checking bench for the per-port lookup and ptp register bank
`timescale 1ns/10ps
module plp_port_config_tb;
  reg         pclk = 1'b0, presetn = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg         global_self_filter_en = 1'b0, frm_valid = 1'b0, frm_tagged = 1'b0, ce = 1'b1;
  reg         frm_vid_member = 1'b0, ptp_valid = 1'b0, ptp_egress_req = 1'b0, er;
  reg  [2:0]  frm_tree_sel = 3'h2;
  reg  [17:0] paddr = 18'h0;
  reg  [31:0] pwdata = 32'h0, rd;
  reg  [11:0] frm_vid = 12'h0;
  reg  [47:0] frm_src_mac = 48'h0;
  reg  [63:0] ptp_corr_in = 64'h0;
  wire [31:0] prdata;
  wire [11:0] lookup_vid;
  wire [63:0] ptp_corr_out;
  wire [15:0] rx_wire_delay_ns, tx_wire_delay_ns;
  wire        pready, pslverr, frm_drop, frm_learn, mac_auth_en, port_tx_en, port_rx_en;
  wire        port_learn_dis, ptp_corr_valid;
  integer     err_total = 0, checks = 0, k;

  plp_port_config DUT (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb(4'hf), .prdata, .pready, .pslverr, .port_num(3'h3), .global_self_filter_en,
    .switch_mac(48'h0a0b0c0d0e0f), .frm_valid, .frm_tagged, .frm_vid,
    .port_default_vid(12'h00a), .frm_vid_member, .frm_src_mac, .frm_tree_sel, .lookup_vid,
    .frm_drop, .frm_learn, .mac_auth_en, .port_tx_en, .port_rx_en, .port_learn_dis,
    .ptp_valid, .ptp_egress_req, .ptp_corr_in, .ptp_corr_out, .ptp_corr_valid,
    .rx_wire_delay_ns, .tx_wire_delay_ns);

  always #2.5 pclk = ~pclk;

  // ---------------------------------------------
  // tasks
  // ---------------------------------------------
  task chk(input string nm, input [63:0] got, input [63:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("CHECK FAILED %0s expected %h seen %h", nm, exp, got);
      end
    end
  endtask

  task end_sim;
    begin
      $display("comparisons %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask

  // one apb transfer; waits for ready, takes data at that edge, then releases
  task apb(input w, input [3:0] n, input [11:0] off, input [31:0] d);
    integer i;
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {n, off, 2'b00};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      i = 0;
      while (pready !== 1'b1 && i < 20) begin
        @(posedge pclk);
        i = i + 1;
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (i == 20)
        chk("apb answer", 1, 0);
    end
  endtask

  task rdchk(input [11:0] off, input [31:0] exp);
    begin
      apb(1'b0, 4'h3, off, 32'h0);
      chk("read data", rd, exp);
      chk("read error", er, 0);
    end
  endtask

  task frame(input [7:0] ctl, input g, input [11:0] v, input m, input s, input [2:0] ts,
             input [11:0] ev, input ed);
    begin
      apb(1'b1, 4'h3, 12'hb00, {24'h0, ctl});
      @(posedge pclk);
      global_self_filter_en <= g;
      frm_tagged <= 1'b1;
      frm_vid <= v;
      frm_vid_member <= m;
      frm_src_mac <= s ? 48'h0a0b0c0d0e0f : 48'h0a0b0c0d0e1f;
      frm_tree_sel <= ts;
      frm_valid <= 1'b1;
      @(posedge pclk);
      frm_valid <= 1'b0;
      @(negedge pclk);
      chk("lookup_vid", lookup_vid, ev);
      chk("frm_drop", frm_drop, ed);
    end
  endtask

  task ptp(input eg, input [63:0] ci, input [63:0] ex);
    begin
      @(posedge pclk);
      ptp_egress_req <= eg;
      ptp_corr_in <= ci;
      ptp_valid <= 1'b1;
      @(posedge pclk);
      ptp_valid <= 1'b0;
      @(negedge pclk);
      chk("ptp_corr_out", ptp_corr_out, ex);
      chk("ptp_corr_valid", ptp_corr_valid, 1);
    end
  endtask

  // ---------------------------------------------
  // tests
  // ---------------------------------------------
  initial begin
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(12'hc00, 32'h019f);
    rdchk(12'hc02, 32'h002d);
    rdchk(12'hc04, 32'h0);
    rdchk(12'hb00, 32'h0);
    rdchk(12'hb04, 32'h6);
    apb(1'b1, 4'h3, 12'hb00, 32'hff);
    rdchk(12'hb00, 32'hfa);
    $display("test reset and reserved done");
    for (k = 0; k < 8; k = k + 1) begin
      apb(1'b1, 4'h3, 12'hb01, 32'hf8 | k);
      apb(1'b1, 4'h3, 12'hb04, 32'hf8 | k);
    end
    for (k = 0; k < 8; k = k + 1) begin
      apb(1'b1, 4'h3, 12'hb01, 32'hf8 | k);
      rdchk(12'hb01, 32'hf8 | k);
      rdchk(12'hb04, k);
      @(negedge pclk);
      chk("port_tx_en", port_tx_en, k[2]);
      chk("port_rx_en", port_rx_en, k[1]);
      chk("port_learn_dis", port_learn_dis, k[0]);
    end
    $display("test tree instances done");
    frame(8'h00, 0, 12'h000, 1, 0, 3'h2, 12'h00a, 0);
    frame(8'h80, 0, 12'h000, 1, 0, 3'h2, 12'h000, 0);
    frame(8'h40, 0, 12'h005, 0, 0, 3'h2, 12'h005, 1);
    frame(8'h00, 0, 12'h005, 0, 0, 3'h2, 12'h005, 0);
    frame(8'h20, 0, 12'h005, 1, 0, 3'h2, 12'h005, 1);
    frame(8'h20, 0, 12'h00a, 1, 0, 3'h2, 12'h00a, 0);
    frame(8'h08, 0, 12'h005, 1, 1, 3'h2, 12'h005, 0);
    frame(8'h08, 1, 12'h005, 1, 1, 3'h2, 12'h005, 1);
    frame(8'h00, 1, 12'h005, 1, 1, 3'h2, 12'h005, 0);
    chk("frm_learn", frm_learn, 1);
    frame(8'h00, 0, 12'h005, 1, 0, 3'h3, 12'h005, 0);
    chk("frm_learn", frm_learn, 0);
    frame(8'h00, 0, 12'h005, 1, 0, 3'h1, 12'h005, 1);
    chk("mac_auth_en", mac_auth_en, 0);
    apb(1'b1, 4'h3, 12'hb00, 32'h10);
    @(negedge pclk);
    chk("mac_auth_en", mac_auth_en, 1);
    $display("test lookup done");
    apb(1'b1, 4'h3, 12'hc04, 32'h8064);
    ptp(0, 64'h3e8, 64'h384);
    ptp(1, 64'h3e8, 64'h44c);
    apb(1'b1, 4'h3, 12'hc04, 32'h0064);
    ptp(0, 64'h3e8, 64'h44c);
    ptp(1, 64'h3e8, 64'h384);
    @(posedge pclk);
    ce <= 1'b0;
    ptp_valid <= 1'b1;
    @(posedge pclk);
    ptp_valid <= 1'b0;
    @(negedge pclk);
    chk("ce freeze", ptp_corr_valid, 0);
    @(posedge pclk);
    ce <= 1'b1;
    apb(1'b1, 4'h3, 12'hc00, 32'hffff1234);
    apb(1'b1, 4'h3, 12'hc02, 32'h0000abcd);
    rdchk(12'hc00, 32'h1234);
    chk("rx_wire_delay_ns", rx_wire_delay_ns, 16'h1234);
    chk("tx_wire_delay_ns", tx_wire_delay_ns, 16'habcd);
    $display("test ptp done");
    apb(1'b1, 4'h5, 12'hc00, 32'h5555);
    chk("other port error", er, 1);
    rdchk(12'hc00, 32'h1234);
    apb(1'b0, 4'h3, 12'hb02, 32'h0);
    chk("unmapped error", er, 1);
    chk("unmapped data", rd, 0);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(12'hc00, 32'h019f);
    $display("test map and second reset done");
    end_sim;
  end

  initial begin
    #20000;
    err_total = err_total + 1;
    end_sim;
  end
endmodule // plp_port_config_tb

/* verilog/plp_asym_apply.v */
// signed asymmetry correction applied to a ptp correction value
`timescale 1ns/10ps
`include "plp_regs.vh"

module plp_asym_apply (
  input  wire [15:0] asym_reg,
  input  wire        is_egress_req,
  input  wire [63:0] corr_in,
  output wire [63:0] corr_out
);

  wire [63:0] mag_ext;
  wire [63:0] signed_mag;

  assign mag_ext    = {49'h0, asym_reg[14:0]};
  assign signed_mag = asym_reg[`PLP_BIT_ASYM_SIGN] ? (~mag_ext + 64'h1) : mag_ext;
  assign corr_out   = is_egress_req ? (corr_in - signed_mag) : (corr_in + signed_mag);

endmodule // plp_asym_apply

/* verilog/plp_port_config.v */
// per-port lookup control, tree instance state and ptp correction registers
//
// Function
// - null-vid bit set looks up vid zero, else uses port default vid
// - ingress filtering drops frames whose vlan membership excludes this port
// - drop-non-default bit drops frames whose vid differs from port default
// - mac 802.1x bit enables mac authentication in lookup engine
// - self-address filter drops frames whose source mac equals switch mac
// - self filtering needs both port bit and global enable
// - three-bit index selects which of eight tree instances state access uses
// - instance state bit 2 gates transmit, resets to one
// - instance state bit 1 gates receive, resets to one
// - instance state bit 0 disables learning, resets to zero
// - rx wire delay sixteen bits in ns, default 415
// - tx wire delay sixteen bits in ns, default 45
// - asymmetry bit 15 is sign, one means negative
// - magnitude added for ingress sync/pdelay_resp, subtracted for egress requests
// - ptp registers sit at 0xNC00-0xNCFF, port one to seven
//
// The APB slave port was left to the implementer.
`timescale 1ns/10ps
`include "plp_regs.vh"

module plp_port_config (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        ce,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [17:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // lookup engine interface (same clock)
  input  wire [2:0]  port_num,
  input  wire        global_self_filter_en,
  input  wire [47:0] switch_mac,
  input  wire        frm_valid,
  input  wire        frm_tagged,
  input  wire [11:0] frm_vid,
  input  wire [11:0] port_default_vid,
  input  wire        frm_vid_member,
  input  wire [47:0] frm_src_mac,
  input  wire [2:0]  frm_tree_sel,
  output reg  [11:0] lookup_vid,
  output reg         frm_drop,
  output reg         frm_learn,
  output reg         mac_auth_en,
  output reg         port_tx_en,
  output reg         port_rx_en,
  output reg         port_learn_dis,
  // ptp timestamp engine interface
  input  wire        ptp_valid,
  input  wire        ptp_egress_req,
  input  wire [63:0] ptp_corr_in,
  output reg  [63:0] ptp_corr_out,
  output reg         ptp_corr_valid,
  output reg  [15:0] rx_wire_delay_ns,
  output reg  [15:0] tx_wire_delay_ns
);

  // ---------------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------------
  reg  [7:0]  lookup_ctrl_r;
  reg  [2:0]  tree_instance_index_r;
  reg  [4:0]  tree_index_rsvd_r;
  reg  [15:0] rx_delay_r;
  reg  [15:0] tx_delay_r;
  reg  [15:0] asym_r;

  wire [2:0]  tree_state [0:`PLP_TREE_COUNT-1];
  wire [`PLP_TREE_COUNT-1:0] tree_wr;
  wire [63:0] corr_calc;

  // ---------------------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------------------
  wire [3:0]  addr_port;
  wire [11:0] addr_off;
  wire        port_ok;
  wire        acc;
  wire        wr_acc;
  wire        hit_lookup;
  wire        hit_index;
  wire        hit_state;
  wire        hit_rx;
  wire        hit_tx;
  wire        hit_asym;
  wire        hit_any;
  wire [2:0]  sel_state;

  assign addr_port  = paddr[17:14];
  assign addr_off   = paddr[13:`PLP_APB_SHIFT];
  // port nibble selects port one to seven
  assign port_ok    = (addr_port >= `PLP_FIRST_PORT) && (addr_port <= `PLP_LAST_PORT) &&
                      (addr_port == {1'b0, port_num});
  assign acc        = psel && penable && ce;
  assign wr_acc     = acc && pwrite && port_ok;
  assign hit_lookup = (addr_off == `PLP_OFF_LOOKUP_CTRL);
  assign hit_index  = (addr_off == `PLP_OFF_TREE_INDEX);
  assign hit_state  = (addr_off == `PLP_OFF_TREE_STATE);
  assign hit_rx     = (addr_off == `PLP_OFF_RX_LATENCY);
  assign hit_tx     = (addr_off == `PLP_OFF_TX_LATENCY);
  assign hit_asym   = (addr_off == `PLP_OFF_ASYMMETRY);
  assign hit_any    = port_ok && (hit_lookup || hit_index || hit_state ||
                                  hit_rx || hit_tx || hit_asym);
  assign sel_state  = tree_state[tree_instance_index_r];

  // ---------------------------------------------------------------------------
  // tree instance states
  // ---------------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `PLP_TREE_COUNT; gi = gi + 1) begin : g_tree
      assign tree_wr[gi] = wr_acc && hit_state && pstrb[0] &&
                           ({29'h0, tree_instance_index_r} == gi);
      plp_tree_state u_state (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .wr_en   (tree_wr[gi]),
        .wr_data (pwdata[2:0]),
        .state   (tree_state[gi])
      );
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------------------
  wire        wr_lookup;
  wire        wr_index;
  wire [1:0]  wr_rx;
  wire [1:0]  wr_tx;
  wire [1:0]  wr_asym;

  assign wr_lookup = wr_acc && hit_lookup && pstrb[0];
  assign wr_index  = wr_acc && hit_index && pstrb[0];
  assign wr_rx     = {2{wr_acc && hit_rx}} & pstrb[1:0];
  assign wr_tx     = {2{wr_acc && hit_tx}} & pstrb[1:0];
  assign wr_asym   = {2{wr_acc && hit_asym}} & pstrb[1:0];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lookup_ctrl_r <= 8'h00;
    end else if (wr_lookup) begin
      lookup_ctrl_r <= pwdata[7:0] & `PLP_LOOKUP_RW_MASK;
    end
  end

  // instance index, reserved upper bits kept
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tree_instance_index_r <= 3'h0;
      tree_index_rsvd_r     <= 5'h00;
    end else if (wr_index) begin
      tree_instance_index_r <= pwdata[2:0];
      tree_index_rsvd_r     <= pwdata[7:3];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_delay_r <= `PLP_RST_RX_LATENCY;
    end else begin
      if (wr_rx[0]) rx_delay_r[7:0]  <= pwdata[7:0];
      if (wr_rx[1]) rx_delay_r[15:8] <= pwdata[15:8];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_delay_r <= `PLP_RST_TX_LATENCY;
    end else begin
      if (wr_tx[0]) tx_delay_r[7:0]  <= pwdata[7:0];
      if (wr_tx[1]) tx_delay_r[15:8] <= pwdata[15:8];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      asym_r <= `PLP_RST_ASYMMETRY;
    end else begin
      if (wr_asym[0]) asym_r[7:0]  <= pwdata[7:0];
      if (wr_asym[1]) asym_r[15:8] <= pwdata[15:8];
    end
  end

  // ---------------------------------------------------------------------------
  // apb response, one wait state
  // ---------------------------------------------------------------------------
  reg [31:0] rd_nxt;

  always @* begin
    rd_nxt = 32'h0;
    if (port_ok) begin
      case (addr_off)
        `PLP_OFF_LOOKUP_CTRL: begin
          rd_nxt = {24'h0, lookup_ctrl_r};
        end
        `PLP_OFF_TREE_INDEX: begin
          rd_nxt = {24'h0, tree_index_rsvd_r, tree_instance_index_r};
        end
        `PLP_OFF_TREE_STATE: begin
          rd_nxt = {29'h0, sel_state};
        end
        `PLP_OFF_RX_LATENCY: begin
          rd_nxt = {16'h0, rx_delay_r};
        end
        `PLP_OFF_TX_LATENCY: begin
          rd_nxt = {16'h0, tx_delay_r};
        end
        `PLP_OFF_ASYMMETRY: begin
          rd_nxt = {16'h0, asym_r};
        end
        default: begin
          rd_nxt = 32'h0;
        end
      endcase
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (ce) begin
      if (psel && penable && !pready) begin
        pready  <= 1'b1;
        pslverr <= !hit_any;
        prdata  <= pwrite ? 32'h0 : rd_nxt;
      end else begin
        pready  <= 1'b0;
        pslverr <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // lookup decisions, registered one cycle after frm_valid
  // ---------------------------------------------------------------------------
  wire [2:0]  fst;
  wire        self_match;
  wire        vid_zero;
  wire [11:0] eff_vid;
  wire        filt_drop;
  wire        pvid_drop;
  wire        rx_block;

  assign fst        = tree_state[frm_tree_sel];
  assign vid_zero   = frm_tagged && (frm_vid == 12'h000);
  assign eff_vid    = (vid_zero && !lookup_ctrl_r[`PLP_BIT_ZERO_VID]) ?
                      port_default_vid : frm_vid;
  assign self_match = lookup_ctrl_r[`PLP_BIT_SELF_FILTER] && global_self_filter_en &&
                      (frm_src_mac == switch_mac);

  assign filt_drop  = lookup_ctrl_r[`PLP_BIT_INGRESS_FILT] && !frm_vid_member;
  assign pvid_drop  = lookup_ctrl_r[`PLP_BIT_DROP_NON_PVID] && (eff_vid != port_default_vid);
  assign rx_block   = !fst[`PLP_BIT_RX_EN];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lookup_vid     <= 12'h000;
      frm_drop       <= 1'b0;
      frm_learn      <= 1'b0;
    end else if (ce) begin
      lookup_vid     <= eff_vid;
      frm_drop       <= frm_valid && (filt_drop || pvid_drop || self_match || rx_block);
      frm_learn      <= frm_valid && fst[`PLP_BIT_RX_EN] && !fst[`PLP_BIT_LEARN_DIS];
    end
  end

  // ---------------------------------------------------------------------------
  // port gates from the index-selected instance, mac_auth_en from lookup control
  // ---------------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mac_auth_en    <= 1'b0;
      port_tx_en     <= 1'b1;
      port_rx_en     <= 1'b1;
      port_learn_dis <= 1'b0;
    end else if (ce) begin
      mac_auth_en    <= lookup_ctrl_r[`PLP_BIT_MAC_8021X];
      port_tx_en     <= sel_state[`PLP_BIT_TX_EN];
      port_rx_en     <= sel_state[`PLP_BIT_RX_EN];
      port_learn_dis <= sel_state[`PLP_BIT_LEARN_DIS];
    end
  end

  // ---------------------------------------------------------------------------
  // ptp corrections
  // ---------------------------------------------------------------------------
  plp_asym_apply u_asym (
    .asym_reg      (asym_r),
    .is_egress_req (ptp_egress_req),
    .corr_in       (ptp_corr_in),
    .corr_out      (corr_calc)
  );

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptp_corr_out     <= 64'h0;
      ptp_corr_valid   <= 1'b0;
    end else if (ce) begin
      ptp_corr_valid   <= ptp_valid;
      if (ptp_valid) ptp_corr_out <= corr_calc;
    end
  end

  // ---------------------------------------------------------------------------
  // wire delay outputs
  // ---------------------------------------------------------------------------
  // delays to timestamp engine
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_wire_delay_ns <= `PLP_RST_RX_LATENCY;
      tx_wire_delay_ns <= `PLP_RST_TX_LATENCY;
    end else if (ce) begin
      rx_wire_delay_ns <= rx_delay_r;
      tx_wire_delay_ns <= tx_delay_r;
    end
  end

endmodule // plp_port_config

/* verilog/plp_regs.vh */
// register offsets, field positions, reset values for the per-port lookup/ptp bank
`ifndef PLP_REGS_VH
`define PLP_REGS_VH

// word offsets within one port block (port number in paddr[17:14])
`define PLP_OFF_LOOKUP_CTRL   12'hb00
`define PLP_OFF_TREE_INDEX    12'hb01
`define PLP_OFF_TREE_STATE    12'hb04
`define PLP_OFF_RX_LATENCY    12'hc00
`define PLP_OFF_TX_LATENCY    12'hc02
`define PLP_OFF_ASYMMETRY     12'hc04
// apb word addresses are four times the printed index
`define PLP_APB_SHIFT         2

// lookup control fields
`define PLP_BIT_ZERO_VID      7
`define PLP_BIT_INGRESS_FILT  6
`define PLP_BIT_DROP_NON_PVID 5
`define PLP_BIT_MAC_8021X     4
`define PLP_BIT_SELF_FILTER   3
`define PLP_BIT_RSVD_RW       1
`define PLP_LOOKUP_RW_MASK    8'hfa

// tree instance state fields
`define PLP_BIT_TX_EN         2
`define PLP_BIT_RX_EN         1
`define PLP_BIT_LEARN_DIS     0
`define PLP_TREE_COUNT        8
`define PLP_TREE_STATE_RST    3'h6

// ptp fields
`define PLP_BIT_ASYM_SIGN     15
`define PLP_RST_RX_LATENCY    16'h019f
`define PLP_RST_TX_LATENCY    16'h002d
`define PLP_RST_ASYMMETRY     16'h0000

`define PLP_FIRST_PORT        4'h1
`define PLP_LAST_PORT         4'h7

`endif

/* verilog/plp_tree_state.v */
// one spanning-tree instance state holder (tx enable, rx enable, learning disable)
`timescale 1ns/10ps
`include "plp_regs.vh"

module plp_tree_state (
  input  wire       pclk,
  input  wire       presetn,
  input  wire       ce,
  input  wire       wr_en,
  input  wire [2:0] wr_data,
  output wire [2:0] state
);

  reg [2:0] state_r;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= `PLP_TREE_STATE_RST;
    end else if (ce && wr_en) begin
      state_r <= wr_data;
    end
  end

  assign state = state_r;

endmodule // plp_tree_state
